// ==== design/acc_pkg_map.svh ====
// timing and width constants for the converter bus controller
// assumes: 25 MHz system clock (40 ns period)
`ifndef ACC_PKG_MAP_SVH
`define ACC_PKG_MAP_SVH
`define ACC_CLK_NS 40
`define ACC_T_WIDTH_NS 300
`define ACC_T_CONV_NS 10000
`define ACC_T_ACCESS_NS 250
`define ACC_T_STATUS_DATA_NS 250
`define ACC_T_START_NS 700
`define ACC_T_HOLD_NS 25
`define ACC_T_FLOAT_NS 150
`define ACC_CYC_WIDTH ((`ACC_T_WIDTH_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CYC_ACCESS ((`ACC_T_ACCESS_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CYC_SDATA ((`ACC_T_STATUS_DATA_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CYC_START ((`ACC_T_START_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CYC_FLOAT ((`ACC_T_FLOAT_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CYC_CONT ((`ACC_T_CONV_NS + `ACC_T_ACCESS_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CNT_W 9
`define ACC_SYNC_CYC 2
`endif

// ==== design/acc_pkg.sv ====
// types shared by the converter bus controller
// assumes: nothing outside
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b000,
        ACC_STROBE = 3'b001,
        ACC_WAIT_HI = 3'b011,
        ACC_WAIT_LO = 3'b010,
        ACC_READ = 3'b110,
        ACC_RELEASE = 3'b111
    } acc_state_t;

    typedef struct packed {
        logic sel_a_n;
        logic sel_b_n;
        logic dir;
        logic coding;
        logic input_polarity_select;
    } acc_pins_t;
endpackage

// ==== design/acc_sync.sv ====
// two-flop synchroniser, one per bit
// assumes: inputs asynchronous to clk_sys
`timescale 1ns/1ps
module acc_sync #(
    parameter int WIDTH = 9
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    stage1[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// ==== design/acc_ctrl.sv ====
// controller that drives the 8-bit converter over its select, direction and data pins
// assumes: pins of the converter are asynchronous; user side is on clk_sys
//
// Behaviour
// - hold strobe low at least 300 ns
// - stand-alone: tie selects, pulse direction low
// - while selected, raise direction only while status high; idle raises it with selects high
// - continuous: direction low at least 10.25 us
// - coding and polarity set before convert
`timescale 1ns/1ps
`include "acc_pkg_map.svh"
module acc_ctrl
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // user request side
    input wire logic req_convert,
    input wire logic req_continuous,
    input wire logic req_coding,
    input wire logic req_input_polarity_select,
    output logic busy,
    output logic result_valid,
    output logic [7:0] result,
    // converter pins
    output acc_pins_t pins,
    input wire logic adc_status,
    input wire logic [7:0] adc_data
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [8:0] sync_bus;
    logic status_s;
    logic [7:0] data_s;

    acc_sync #(.WIDTH(9)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({adc_status, adc_data}),
        .sync_out(sync_bus)
    );
    assign status_s = sync_bus[8];
    assign data_s = sync_bus[7:0];

    // ------------------------------------------------------------
    // status edge
    // ------------------------------------------------------------
    // synced status lags the pin, so its level may already be stale;
    // only its rising edge promises a whole conversion still ahead
    logic status_d;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_d <= 1'b0;
        end else begin
            status_d <= status_s;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    localparam logic [`ACC_CNT_W-1:0] CYC_WIDTH = `ACC_CNT_W'(`ACC_CYC_WIDTH);
    localparam logic [`ACC_CNT_W-1:0] CYC_ACCESS = `ACC_CNT_W'(`ACC_CYC_ACCESS + `ACC_CYC_SDATA);
    localparam logic [`ACC_CNT_W-1:0] CYC_START = `ACC_CNT_W'(`ACC_CYC_START + `ACC_SYNC_CYC);
    localparam logic [`ACC_CNT_W-1:0] CYC_FLOAT = `ACC_CNT_W'(`ACC_CYC_FLOAT);
    localparam logic [`ACC_CNT_W-1:0] CYC_CONT = `ACC_CNT_W'(`ACC_CYC_CONT);
    localparam logic [`ACC_CNT_W-1:0] CNT_ONE = `ACC_CNT_W'(1);

    acc_state_t state;
    logic [`ACC_CNT_W-1:0] cnt;
    logic [`ACC_CNT_W-1:0] low_time;
    logic cont_mode;
    logic cnt_done;

    assign cnt_done = (cnt == '0);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ACC_IDLE;
            cnt <= '0;
            cont_mode <= 1'b0;
        end else begin
            if (!cnt_done) begin
                cnt <= cnt - CNT_ONE;
            end
            case (state)
                ACC_IDLE: begin
                    // no new start while the converter still reports busy
                    if (req_convert && !status_s) begin
                        state <= ACC_STROBE;
                        cont_mode <= req_continuous;
                        cnt <= CYC_WIDTH;
                    end
                end
                ACC_STROBE: begin
                    if (cnt_done) begin
                        state <= ACC_WAIT_HI;
                        cnt <= CYC_START;
                    end
                end
                ACC_WAIT_HI: begin
                    // status must show within the start delay, else give up
                    if (status_s) begin
                        state <= ACC_WAIT_LO;
                    end else if (cnt_done) begin
                        state <= ACC_RELEASE;
                        cnt <= CYC_FLOAT;
                    end
                end
                ACC_WAIT_LO: begin
                    if (!status_s && !(cont_mode && !pins.dir)) begin
                        state <= ACC_READ;
                        cnt <= CYC_ACCESS;
                    end
                end
                ACC_READ: begin
                    if (cnt_done) begin
                        state <= ACC_RELEASE;
                        cnt <= CYC_FLOAT;
                    end
                end
                ACC_RELEASE: begin
                    if (cnt_done) begin
                        state <= ACC_IDLE;
                    end
                end
                default: begin
                    state <= ACC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // continuous-mode low time of direction
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            low_time <= '0;
        end else if (pins.dir) begin
            low_time <= '0;
        end else if (low_time != CYC_CONT) begin
            low_time <= low_time + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pins <= '{sel_a_n: 1'b1, sel_b_n: 1'b1, dir: 1'b1, coding: 1'b0, input_polarity_select: 1'b0};
        end else begin
            case (state)
                ACC_IDLE: begin
                    pins.sel_a_n <= 1'b1;
                    pins.sel_b_n <= 1'b1;
                    pins.dir <= 1'b1;
                    if (req_convert && !status_s) begin
                        pins.coding <= req_coding;
                        pins.input_polarity_select <= req_input_polarity_select;
                        // both selects tied together as one strobe
                        pins.sel_a_n <= 1'b0;
                        pins.sel_b_n <= 1'b0;
                        pins.dir <= 1'b0;
                    end
                end
                ACC_WAIT_HI: begin
                    if (status_s && !cont_mode) begin
                        pins.dir <= 1'b1;
                    end
                end
                ACC_WAIT_LO: begin
                    // lift direction only on a fresh status rise, after a long enough low time
                    if (cont_mode && status_s && !status_d && !req_continuous && low_time == CYC_CONT) begin
                        pins.dir <= 1'b1;
                    end
                end
                ACC_RELEASE: begin
                    pins.sel_a_n <= 1'b1;
                    pins.sel_b_n <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // user side
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy <= 1'b0;
            result_valid <= 1'b0;
            result <= 8'h00;
        end else begin
            busy <= (state != ACC_IDLE);
            result_valid <= 1'b0;
            // sample at the end of access time, bus data settled
            if (state == ACC_READ && cnt_done) begin
                result <= data_s;
                result_valid <= 1'b1;
            end
        end
    end
endmodule

// ==== bench/acc_ctrl_properties.sv ====
// checker for the converter bus controller, bound to acc_ctrl
// assumes: one clock domain, status seen through a two-flop synchroniser
`timescale 1ns/1ps
module acc_ctrl_chk
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // user side
    input wire logic req_convert,
    input wire logic req_continuous,
    input wire logic req_coding,
    input wire logic req_input_polarity_select,
    input wire logic busy,
    input wire logic result_valid,
    input wire logic [7:0] result,
    // converter pins
    input wire acc_pins_t pins,
    input wire logic adc_status,
    input wire logic [7:0] adc_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_start;
        $fell(pins.sel_a_n) && !pins.dir;
    endsequence
    sequence s_release;
        !result_valid ##[0:7] pins.sel_a_n;
    endsequence
    AST_SEL_TIED: assert property (pins.sel_a_n == pins.sel_b_n)
        else $error("selects differ");
    AST_START_DIR: assert property ($fell(pins.sel_a_n) |-> !pins.dir)
        else $error("select fell without convert direction");
    AST_STROBE_WIDTH: assert property (s_start |=> !pins.sel_a_n [*7])
        else $error("strobe shorter than 8 cycles");
    AST_NO_START_BUSY: assert property (s_start |-> !$past(adc_status, 3))
        else $error("start while converting");
    AST_CFG_SAMPLED: assert property (s_start |-> pins.coding == $past(req_coding)
        && pins.input_polarity_select == $past(req_input_polarity_select))
        else $error("coding or polarity not set at start");
    AST_DIR_RISE: assert property ($rose(pins.dir) && !pins.sel_a_n |-> $past(adc_status, 3) && adc_status)
        else $error("direction raised while status low");
    AST_RESULT_AFTER_STATUS: assert property ($fell(adc_status) && pins.dir && !pins.sel_a_n |-> ##[10:24] result_valid)
        else $error("no result after status fell");
    AST_DATA_HELD: assert property ($fell(adc_status) && pins.dir |-> !pins.sel_a_n [*8])
        else $error("selects rose before read");
    AST_PULSE_RELEASE: assert property (result_valid |=> s_release)
        else $error("result pulse or release wrong");
endmodule

// ==== bench/acc_dev_model.sv ====
// behavioural converter on the far side of the pins
// assumes: sampled on clk_sys; data bus has no pull, shows a toggling pattern when released
`timescale 1ns/1ps
module acc_dev_model
    import acc_pkg::*;
#(
    parameter int CONV_CYC = 100
) (
    // clock
    input wire logic clk_sys,
    // pins
    input wire acc_pins_t pins,
    output logic adc_status,
    output logic [7:0] adc_data,
    // observation
    output logic [7:0] conv_count,
    output logic [1:0] cfg_seen
);
    logic act;
    logic pat;
    logic [3:0] low_cnt;
    logic [3:0] rd_cnt;
    logic [7:0] conv_cnt;
    logic [7:0] value;
    assign act = !pins.sel_a_n && !pins.sel_b_n;
    assign adc_data = (act && pins.dir && !adc_status && rd_cnt >= 4'h6) ? value : {8{pat}};
    initial begin
        {pat, adc_status, low_cnt, rd_cnt, conv_cnt, value, conv_count, cfg_seen} = '0;
    end
    always @(posedge clk_sys) begin
        pat <= ~pat;
        rd_cnt <= (act && pins.dir && !adc_status) ? rd_cnt + {3'h0, rd_cnt != 4'hf} : 4'h0;
        if (adc_status) begin
            // dir ignored here: a started conversion always finishes
            conv_cnt <= conv_cnt - 8'h01;
            if (conv_cnt == 8'h00) begin
                adc_status <= 1'b0;
                value <= 8'h5a + conv_count;
                conv_count <= conv_count + 8'h01;
                low_cnt <= 4'h0;
            end
        end else if (act && !pins.dir) begin
            low_cnt <= low_cnt + 4'h1;
            if (low_cnt == 4'h8) begin
                adc_status <= 1'b1;
                conv_cnt <= 8'(CONV_CYC);
                cfg_seen <= {pins.coding, pins.input_polarity_select};
            end
        end else begin
            low_cnt <= 4'h0;
        end
    end
endmodule

// ==== bench/acc_ctrl_bench.sv ====
// self-checking bench for acc_ctrl against the converter model
// assumes: 25 MHz clock, inputs driven on the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module acc_ctrl_bench;
    import acc_pkg::*;
    logic clk_sys = 0, srst = 1, req_convert = 0, req_continuous = 0;
    logic req_coding = 0, req_input_polarity_select = 0, busy, result_valid, adc_status;
    logic [7:0] result, adc_data, conv_count, k;
    logic [1:0] cfg_seen;
    acc_pins_t pins;
    int miscompares = 0, samples_checked = 0;
    always #20 clk_sys = ~clk_sys;
    acc_ctrl acc_ctrl_inst(.clk_sys(clk_sys), .srst(srst), .req_convert(req_convert),
        .req_continuous(req_continuous), .req_coding(req_coding),
        .req_input_polarity_select(req_input_polarity_select), .busy(busy), .result_valid(result_valid),
        .result(result), .pins(pins), .adc_status(adc_status), .adc_data(adc_data));
    acc_dev_model acc_dev_model_inst(.clk_sys(clk_sys), .pins(pins), .adc_status(adc_status),
        .adc_data(adc_data), .conv_count(conv_count), .cfg_seen(cfg_seen));
    task results();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_done();
        int n = 0;
        while (result_valid !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("done", 1'b1, result_valid)
    endtask
    task automatic single(input logic c, input logic p);
        @(negedge clk_sys);
        {req_coding, req_input_polarity_select, req_convert} = {c, p, 1'b1};
        k = conv_count;
        @(negedge clk_sys);
        req_convert = 0;
        repeat (30) @(negedge clk_sys);
        req_convert = 1;
        @(negedge clk_sys);
        req_convert = 0;
        `CHK("busy", 1'b1, busy)
        wait_done();
        `CHK("result", 8'h5a + k, result)
        `CHK("config", {c, p}, cfg_seen)
        repeat (30) @(negedge clk_sys);
        `CHK("select", 1'b1, pins.sel_a_n)
        `CHK("status", 1'b0, adc_status)
        $display("single conversion test done");
    endtask
    task automatic continuous();
        int n = 0;
        @(negedge clk_sys);
        {req_continuous, req_convert} = 2'b11;
        k = conv_count;
        @(negedge clk_sys);
        req_convert = 0;
        while (conv_count < k + 8'h03 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        req_continuous = 0;
        wait_done();
        `CHK("final", 1'b1, conv_count == k + 8'h03 || conv_count == k + 8'h04)
        `CHK("result", 8'h5a + conv_count - 8'h01, result)
        $display("continuous conversion test done");
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        srst = 0;
        `CHK("reset select", 1'b1, pins.sel_a_n)
        `CHK("reset busy", 1'b0, busy)
        for (int i = 0; i < 4; i++) single(i[1], i[0]);
        continuous();
        results();
    end
    initial begin
        #400000;
        miscompares++;
        results();
    end
endmodule
bind acc_ctrl acc_ctrl_chk acc_ctrl_chk_inst(.clk_sys(clk_sys), .srst(srst), .req_convert(req_convert),
    .req_continuous(req_continuous), .req_coding(req_coding),
    .req_input_polarity_select(req_input_polarity_select), .busy(busy), .result_valid(result_valid),
    .result(result), .pins(pins), .adc_status(adc_status), .adc_data(adc_data));
